/* File: hw/serial_link_pkg.sv */
// constants shared by the serial host link and its byte transmitter
package serial_link_pkg;

   // clock and default line settings (8 data bits, no parity, one stop bit)
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned BAUD_DEFAULT = 115_200;
   localparam int unsigned BIT_CYCLES = (CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT;
   localparam int CNT_W = 16;
   localparam logic [3:0] FRAME_LAST_BIT = 4'h9;
   localparam logic [3:0] DATA_LAST_BIT = 4'h8;

   // packet type codes carried in header byte 0
   localparam logic [7:0] PKT_CMD = 8'h01;
   localparam logic [7:0] PKT_RSP = 8'h02;
   localparam logic [7:0] PKT_EVT = 8'h03;

   // byte positions inside an outgoing packet
   localparam logic [2:0] IDX_TYPE = 3'h0;
   localparam logic [2:0] IDX_LEN_LO = 3'h1;
   localparam logic [2:0] IDX_LEN_HI = 3'h2;
   localparam logic [2:0] IDX_ID = 3'h3;
   localparam logic [2:0] IDX_PL_LO = 3'h4;
   localparam logic [2:0] IDX_PL_HI = 3'h5;
   localparam logic [2:0] IDX_SUM = 3'h6;

   // header byte positions while receiving
   localparam logic [1:0] HDR_TYPE = 2'h0;
   localparam logic [1:0] HDR_LEN_LO = 2'h1;
   localparam logic [1:0] HDR_LEN_HI = 2'h2;
   localparam logic [1:0] HDR_ID = 2'h3;

   // outgoing payload is always one 16-bit code
   localparam logic [15:0] OUT_LEN = 16'h0002;

endpackage : serial_link_pkg

/* File: hw/uart_byte_tx.sv */
// asynchronous serial byte transmitter with optional clear-to-send gating
`timescale 1ns/1ps
`default_nettype none

module uart_byte_tx
   import serial_link_pkg::*;
#(
   parameter int unsigned BIT_CYC = BIT_CYCLES
)
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic [7:0] i_byte,
   input wire logic i_flow_en,
   input wire logic i_cts_n,
   output logic o_ready,
   output logic o_busy,
   output logic o_txd
);

   localparam logic [CNT_W-1:0] BIT_CNT = CNT_W'(BIT_CYC - 1);

   typedef struct packed {
      logic busy;
      logic [CNT_W-1:0] cnt;
      logic [3:0] bit_no;
      logic [9:0] sh;
      logic txd;
   } tx_state_t;

   tx_state_t s_q;
   tx_state_t s_d;

   // a byte already started always finishes; the host's deassert only holds the next one
   assign o_ready = !s_q.busy && !(i_flow_en && i_cts_n); // [R18]
   assign o_busy = s_q.busy;
   assign o_txd = s_q.txd;

   // frame: low start bit, data lsb first, one high stop bit
   always_comb
   begin
      s_d = s_q;
      if (!s_q.busy)
      begin
         if (i_start && o_ready)
         begin
            s_d.busy = 1'b1;
            s_d.cnt = BIT_CNT;
            s_d.bit_no = 4'h0;
            s_d.sh = {1'b1, i_byte, 1'b0}; // [R17]
            s_d.txd = 1'b0;
         end
      end
      else if (s_q.cnt != '0)
      begin
         s_d.cnt = s_q.cnt - 1'b1;
      end
      else if (s_q.bit_no == FRAME_LAST_BIT)
      begin
         s_d.busy = 1'b0; // stop bit has lasted a full period
         s_d.txd = 1'b1;
      end
      else
      begin
         s_d.cnt = BIT_CNT;
         s_d.sh = {1'b1, s_q.sh[9:1]}; // [R17]
         s_d.txd = s_q.sh[1];
         s_d.bit_no = s_q.bit_no + 4'h1;
      end
   end

   // line idles high out of reset
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         s_q <= '0;
         s_q.sh <= 10'h3FF;
         s_q.txd <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

endmodule : uart_byte_tx

`default_nettype wire

/* File: hw/serial_api_host_link.sv */
// serial command, response and event link toward an external host controller
// Function
// [R1] line runs 115200 baud, 8 data, no parity, 1 stop, flow control off.
// [R2] host matches the module's configured baud, framing and flow setting.
// [R3] host should enable request/clear-to-send flow control when it can.
// [R4] data-pending output low while transmit data remains, high once drained.
// [R5] host uses data-pending falling edge to start parsing incoming bytes.
// [R6] connection output low only while transparent pipe is fully up.
// [R7] host may gate its sending on the connection output being low.
// [R8] pipe-select strap low forces transparent mode; command traffic unavailable.
// [R9] host drives low-power input around traffic when deep sleep enabled.
// [R10] event packets may be emitted any time, regardless of outstanding commands; here an event waits while a command awaits its response.
// [R11] each accepted command yields exactly one response packet, promptly.
// [R12] events raised during a command wait until its response is sent.
// [R13] host accepts response and event packets and tells them apart.
// [R14] host checks each packet checksum and drops failing packets.
// [R15] every packet starts with a fixed four-byte header: type, length, id.
// [R16] multi-byte fields travel least significant byte first.
// [R17] bytes framed with low start bit, lsb first, then stop bit.
// [R18] with flow control on, transmission pauses while clear-to-send deasserted.
`timescale 1ns/1ps
`default_nettype none

module serial_api_host_link
   import serial_link_pkg::*;
#(
   parameter int unsigned BIT_CYC = BIT_CYCLES
)
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_uart_rxd,
   input wire logic i_cts_n,
   input wire logic i_flow_en,
   input wire logic i_pipe_sel_n,
   input wire logic i_pipe_up,
   input wire logic i_rsp_valid,
   input wire logic [15:0] i_rsp_code,
   input wire logic i_evt_valid,
   input wire logic [15:0] i_evt_code,
   input wire logic i_pipe_tx_valid,
   input wire logic [7:0] i_pipe_tx_data,
   output logic o_uart_txd,
   output logic o_rts_n,
   output logic o_data_ready_n,
   output logic o_conn_n,
   output logic o_cmd_valid,
   output logic [7:0] o_cmd_id,
   output logic o_evt_ready,
   output logic o_pipe_rx_valid,
   output logic [7:0] o_pipe_rx_data,
   output logic o_pipe_tx_ready
);

   localparam logic [CNT_W-1:0] BIT_CNT = CNT_W'(BIT_CYC - 1); // [R1]
   localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(BIT_CYC / 2);

   typedef enum logic [1:0] {P_HDR, P_BODY, P_SUM} parse_st_t;
   typedef enum logic [1:0] {T_IDLE, T_PKT, T_RAW} send_st_t;

   typedef struct packed {
      logic rx_busy;
      logic [CNT_W-1:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [7:0] rx_sh;
      parse_st_t p_st;
      logic [1:0] p_idx;
      logic [15:0] p_len;
      logic [7:0] p_sum;
      logic [7:0] p_id;
      logic cmd_busy;
      logic rsp_wait;
      logic rsp_full;
      logic [15:0] rsp_code;
      logic [7:0] rsp_id;
      logic evt_full;
      logic [15:0] evt_code;
      logic raw_full;
      logic [7:0] raw_data;
      send_st_t t_st;
      logic [2:0] t_idx;
      logic [7:0] t_sum;
      logic [7:0] t_type;
      logic [7:0] t_id;
      logic [15:0] t_code;
      logic cmd_valid;
      logic [7:0] cmd_id;
      logic evt_ready;
      logic pipe_rx_valid;
      logic [7:0] pipe_rx_data;
      logic pipe_tx_ready;
      logic rts_n;
      logic data_ready_n;
      logic conn_n;
   } link_state_t;

   link_state_t s_q;
   link_state_t s_d;
   logic tx_start;
   logic [7:0] tx_byte;
   logic tx_ready;
   logic tx_busy;
   logic byte_stb;
   logic transparent;

   // byte of an outgoing response or event packet at a given position
   function automatic logic [7:0] pkt_byte(input logic [2:0] idx, input logic [7:0] typ,
                                           input logic [7:0] id, input logic [15:0] code,
                                           input logic [7:0] sum);
      case (idx)
         IDX_TYPE: pkt_byte = typ; // [R15]
         IDX_LEN_LO: pkt_byte = OUT_LEN[7:0]; // [R16]
         IDX_LEN_HI: pkt_byte = OUT_LEN[15:8];
         IDX_ID: pkt_byte = id;
         IDX_PL_LO: pkt_byte = code[7:0]; // [R16]
         IDX_PL_HI: pkt_byte = code[15:8];
         default: pkt_byte = sum; // running sum of all bytes before it
      endcase
   endfunction : pkt_byte

   // a tied-low strap or an established pipe puts the port in data mode
   assign transparent = !i_pipe_sel_n || i_pipe_up; // [R8]

   uart_byte_tx #(
      .BIT_CYC(BIT_CYC)
   ) u_tx (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_start(tx_start),
      .i_byte(tx_byte),
      .i_flow_en(i_flow_en),
      .i_cts_n(i_cts_n),
      .o_ready(tx_ready),
      .o_busy(tx_busy),
      .o_txd(o_uart_txd)
   );

   // receiver, parser, packet sender and status lines
   always_comb
   begin
      s_d = s_q;
      byte_stb = 1'b0;
      tx_start = 1'b0;
      tx_byte = 8'h00;
      s_d.cmd_valid = 1'b0;
      s_d.pipe_rx_valid = 1'b0;

      // receive: centre-sample each bit, drop a start glitch or bad stop bit
      if (!s_q.rx_busy)
      begin
         if (!i_uart_rxd)
         begin
            s_d.rx_busy = 1'b1;
            s_d.rx_cnt = HALF_CNT;
            s_d.rx_bit = 4'h0;
         end
      end
      else if (s_q.rx_cnt != '0)
      begin
         s_d.rx_cnt = s_q.rx_cnt - 1'b1;
      end
      else
      begin
         s_d.rx_cnt = BIT_CNT;
         if (s_q.rx_bit == 4'h0)
         begin
            s_d.rx_busy = !i_uart_rxd;
            s_d.rx_bit = 4'h1;
         end
         else if (s_q.rx_bit <= DATA_LAST_BIT)
         begin
            s_d.rx_sh = {i_uart_rxd, s_q.rx_sh[7:1]}; // [R17]
            s_d.rx_bit = s_q.rx_bit + 4'h1;
         end
         else
         begin
            s_d.rx_busy = 1'b0;
            byte_stb = i_uart_rxd;
         end
      end

      // in data mode bytes pass straight to the radio side, no parsing
      if (byte_stb && transparent)
      begin
         s_d.pipe_rx_valid = 1'b1; // [R8]
         s_d.pipe_rx_data = s_q.rx_sh;
      end
      else if (byte_stb)
      begin
         case (s_q.p_st)
            P_HDR:
            begin
               s_d.p_sum = s_q.p_sum + s_q.rx_sh;
               s_d.p_idx = s_q.p_idx + 2'h1;
               case (s_q.p_idx)
                  HDR_TYPE:
                  begin
                     // a second command before the answer is ignored
                     if (s_q.rx_sh == PKT_CMD && !s_q.cmd_busy)
                     begin
                        s_d.cmd_busy = 1'b1; // [R12]
                        s_d.p_sum = s_q.rx_sh;
                     end
                     else
                     begin
                        s_d.p_idx = HDR_TYPE;
                     end
                  end
                  HDR_LEN_LO: s_d.p_len[7:0] = s_q.rx_sh; // [R16]
                  HDR_LEN_HI: s_d.p_len[15:8] = s_q.rx_sh;
                  default:
                  begin
                     s_d.p_id = s_q.rx_sh; // [R15]
                     s_d.p_st = (s_q.p_len == 16'h0000) ? P_SUM : P_BODY;
                  end
               endcase
            end
            P_BODY:
            begin
               // payload is summed and skipped; only the id goes onward
               s_d.p_sum = s_q.p_sum + s_q.rx_sh;
               s_d.p_len = s_q.p_len - 16'h0001;
               if (s_q.p_len == 16'h0001)
               begin
                  s_d.p_st = P_SUM;
               end
            end
            default:
            begin
               s_d.p_st = P_HDR;
               s_d.p_idx = HDR_TYPE;
               if (s_q.rx_sh == s_q.p_sum)
               begin
                  s_d.cmd_valid = 1'b1; // [R11]
                  s_d.cmd_id = s_q.p_id;
                  s_d.rsp_wait = 1'b1;
                  s_d.rsp_id = s_q.p_id;
               end
               else
               begin
                  s_d.cmd_busy = 1'b0; // corrupt command is never answered
               end
            end
         endcase
      end

      // sender: response first, then raw pipe byte, then an event
      case (s_q.t_st)
         T_IDLE:
         begin
            if (s_q.rsp_full)
            begin
               s_d.rsp_full = 1'b0; // [R11]
               s_d.t_st = T_PKT;
               s_d.t_type = PKT_RSP;
               s_d.t_id = s_q.rsp_id;
               s_d.t_code = s_q.rsp_code;
               s_d.t_idx = IDX_TYPE;
               s_d.t_sum = 8'h00;
            end
            else if (s_q.raw_full)
            begin
               s_d.t_st = T_RAW;
            end
            else if (s_q.evt_full && !s_q.cmd_busy) // [R12]
            begin
               s_d.evt_full = 1'b0; // [R10]
               s_d.t_st = T_PKT;
               s_d.t_type = PKT_EVT;
               s_d.t_id = 8'h00;
               s_d.t_code = s_q.evt_code;
               s_d.t_idx = IDX_TYPE;
               s_d.t_sum = 8'h00;
            end
         end
         T_PKT:
         begin
            if (tx_ready)
            begin
               tx_start = 1'b1;
               tx_byte = pkt_byte(s_q.t_idx, s_q.t_type, s_q.t_id, s_q.t_code, s_q.t_sum);
               s_d.t_sum = s_q.t_sum + tx_byte;
               s_d.t_idx = s_q.t_idx + 3'h1;
               if (s_q.t_idx == IDX_SUM)
               begin
                  s_d.t_st = T_IDLE;
                  if (s_q.t_type == PKT_RSP)
                  begin
                     s_d.cmd_busy = 1'b0; // [R12]
                  end
               end
            end
         end
         T_RAW:
         begin
            if (tx_ready)
            begin
               tx_start = 1'b1;
               tx_byte = s_q.raw_data;
               s_d.raw_full = 1'b0;
               s_d.t_st = T_IDLE;
            end
         end
         default: s_d.t_st = T_IDLE;
      endcase

      // one-deep holding slots toward the sender
      if (i_rsp_valid && s_q.rsp_wait)
      begin
         s_d.rsp_wait = 1'b0;
         s_d.rsp_full = 1'b1;
         s_d.rsp_code = i_rsp_code;
      end
      if (i_evt_valid && s_q.evt_ready)
      begin
         s_d.evt_full = 1'b1; // [R10]
         s_d.evt_code = i_evt_code;
      end
      if (i_pipe_tx_valid && s_q.pipe_tx_ready)
      begin
         s_d.raw_full = 1'b1;
         s_d.raw_data = i_pipe_tx_data;
      end
      s_d.evt_ready = !s_d.evt_full && !transparent;
      s_d.pipe_tx_ready = !s_d.raw_full && transparent;

      // receiver never stalls, so the host may always send
      s_d.rts_n = 1'b0;
      // a held event is already waiting data, so it pulls the pending line low too
      s_d.data_ready_n = !(s_d.t_st != T_IDLE || tx_busy || tx_start || s_d.rsp_full
                           || s_d.raw_full || s_d.evt_full); // [R4]
      s_d.conn_n = !i_pipe_up; // [R6]
   end

   // whole state in one register; data-pending and connection lines idle high, rts_n low
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         s_q <= '0;
         s_q.data_ready_n <= 1'b1;
         s_q.conn_n <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign o_rts_n = s_q.rts_n;
   assign o_data_ready_n = s_q.data_ready_n;
   assign o_conn_n = s_q.conn_n;
   assign o_cmd_valid = s_q.cmd_valid;
   assign o_cmd_id = s_q.cmd_id;
   assign o_evt_ready = s_q.evt_ready;
   assign o_pipe_rx_valid = s_q.pipe_rx_valid;
   assign o_pipe_rx_data = s_q.pipe_rx_data;
   assign o_pipe_tx_ready = s_q.pipe_tx_ready;

endmodule : serial_api_host_link

`default_nettype wire

/* File: dv/host_uart_model.sv */
// host-side serial partner: frames bytes toward the link and collects its output
`timescale 1ns/1ps
`default_nettype none

module host_uart_model #(
   parameter int BIT_CYC = 8
)
(
   input wire logic i_mclk,
   input wire logic i_rxd,
   input wire logic i_stall,
   input wire logic i_pend_n,
   output logic o_txd,
   output logic o_cts_n
);
   logic [7:0] rxq[$];
   int n_frame_err;
   int n_pend_fall = 0;

   // line idles high
   initial
   begin
      o_txd = 1'b1;
      n_frame_err = 0;
   end

   // clear-to-send follows the stall wish, moved only at falling edges
   always @(negedge i_mclk) o_cts_n <= i_stall;

   // each fall of data-pending announces a new burst to parse
   always @(negedge i_pend_n) n_pend_fall++;

   // same rate and 8N1 framing as the link, start low, lsb first
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         @(negedge i_mclk);
         o_txd = f[i];
         repeat (BIT_CYC - 1) @(negedge i_mclk);
      end
   endtask : send

   // sample mid-bit; a low stop bit counts as a framing fault
   initial
   forever
   begin
      logic [7:0] b;
      @(negedge i_rxd);
      repeat (BIT_CYC / 2) @(posedge i_mclk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT_CYC) @(posedge i_mclk);
         b[i] = i_rxd;
      end
      repeat (BIT_CYC) @(posedge i_mclk);
      if (i_rxd !== 1'b1) n_frame_err++;
      rxq.push_back(b);
   end
endmodule : host_uart_model
`default_nettype wire

/* File: dv/serial_api_host_link_asserts.sv */
// timing checks on the host link pins
`timescale 1ns/1ps
`default_nettype none

module serial_api_host_link_asserts
   import serial_link_pkg::*;
#(
   parameter int unsigned BIT_CYC = BIT_CYCLES
)
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_cts_n,
   input wire logic i_flow_en,
   input wire logic i_pipe_sel_n,
   input wire logic i_pipe_up,
   input wire logic i_rsp_valid,
   input wire logic i_evt_valid,
   input wire logic o_uart_txd,
   input wire logic o_data_ready_n,
   input wire logic o_conn_n,
   input wire logic o_cmd_valid,
   input wire logic o_evt_ready
);
   logic txd_prev_q;
   logic await_q;
   logic [15:0] fcnt_q;
   logic start_w;

   // a fall only counts as a start bit outside a running frame
   assign start_w = txd_prev_q && !o_uart_txd && (fcnt_q == 16'h0000);

   // frame timer and response-awaited flag
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         txd_prev_q <= 1'b1;
         fcnt_q <= 16'h0000;
         await_q <= 1'b0;
      end
      else
      begin
         txd_prev_q <= o_uart_txd;
         if (start_w)
            fcnt_q <= 16'h0001;
         else if (fcnt_q != 16'h0000)
            fcnt_q <= (fcnt_q == 16'(10 * BIT_CYC - 1)) ? 16'h0000 : fcnt_q + 16'h0001;
         await_q <= o_cmd_valid | (await_q & ~i_rsp_valid);
      end
   end

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   a_cmd_pulse: assert property (o_cmd_valid |=> !o_cmd_valid)
      else $error("command strobe longer than one cycle");
   a_rsp_soon: assert property (await_q && i_rsp_valid && !i_flow_en |-> ##[1:8] start_w)
      else $error("response did not start promptly");
   a_conn_follow: assert property (o_conn_n == !$past(i_pipe_up))
      else $error("connection output wrong");
   a_strap_evt: assert property (!i_pipe_sel_n |=> !o_evt_ready)
      else $error("event slot open in forced data mode");
   a_strap_cmd: assert property (!i_pipe_sel_n ##1 !i_pipe_sel_n |-> !o_cmd_valid)
      else $error("command accepted in forced data mode");
   a_idle_line: assert property (o_data_ready_n |-> o_uart_txd)
      else $error("line active while nothing pending");
   a_pend_queue: assert property (i_evt_valid && o_evt_ready |-> ##[1:2] !o_data_ready_n)
      else $error("pending flag missed queued event");
   a_start_len: assert property (|fcnt_q && fcnt_q < 16'(BIT_CYC) |-> !o_uart_txd)
      else $error("start bit too short");
   a_stop_high: assert property (fcnt_q == 16'(9 * BIT_CYC + BIT_CYC / 2) |-> o_uart_txd)
      else $error("stop bit not high");
   a_cts_gate: assert property (start_w && $past(i_flow_en) |-> !$past(i_cts_n))
      else $error("byte started while clear-to-send off");
   a_evt_slot: assert property (i_evt_valid && o_evt_ready |=> !o_evt_ready)
      else $error("event slot still open after take");

   c_cmd: cover property (o_cmd_valid);
   c_flow: cover property (start_w && i_flow_en);
   c_evt: cover property (i_evt_valid && o_evt_ready);
   c_conn: cover property (!o_conn_n);
endmodule : serial_api_host_link_asserts

bind serial_api_host_link serial_api_host_link_asserts #(.BIT_CYC(BIT_CYC))
   u_serial_api_host_link_asserts (.i_mclk, .i_rst_n, .i_cts_n, .i_flow_en, .i_pipe_sel_n,
   .i_pipe_up, .i_rsp_valid, .i_evt_valid, .o_uart_txd, .o_data_ready_n, .o_conn_n,
   .o_cmd_valid, .o_evt_ready);
`default_nettype wire

/* File: dv/test_serial_api_host_link.sv */
// self-checking bench for the host link with a host serial partner
`timescale 1ns/1ps
`default_nettype none

module test_serial_api_host_link;
   import serial_link_pkg::*;
   localparam int BC = 8;
   logic i_mclk, i_rst_n, i_uart_rxd, i_cts_n, i_flow_en, i_pipe_sel_n, i_pipe_up, stall;
   logic i_rsp_valid, i_evt_valid, i_pipe_tx_valid;
   logic [15:0] i_rsp_code, i_evt_code, code, ecode;
   logic [7:0] i_pipe_tx_data, o_cmd_id, o_pipe_rx_data, id, cmd_id, raw_b;
   logic o_uart_txd, o_rts_n, o_data_ready_n, o_conn_n, o_cmd_valid, o_evt_ready;
   logic o_pipe_rx_valid, o_pipe_tx_ready;
   int n_mismatch = 0;
   int cmp_count = 0;
   int n_cmd = 0;
   int n_raw = 0;

   serial_api_host_link #(.BIT_CYC(BC)) u_serial_api_host_link (.i_mclk, .i_rst_n,
      .i_uart_rxd, .i_cts_n, .i_flow_en, .i_pipe_sel_n, .i_pipe_up, .i_rsp_valid,
      .i_rsp_code, .i_evt_valid, .i_evt_code, .i_pipe_tx_valid, .i_pipe_tx_data,
      .o_uart_txd, .o_rts_n, .o_data_ready_n, .o_conn_n, .o_cmd_valid, .o_cmd_id,
      .o_evt_ready, .o_pipe_rx_valid, .o_pipe_rx_data, .o_pipe_tx_ready);
   host_uart_model #(.BIT_CYC(BC)) u_host_uart_model (.i_mclk, .i_rxd(o_uart_txd),
      .i_stall(stall), .i_pend_n(o_data_ready_n), .o_txd(i_uart_rxd), .o_cts_n(i_cts_n));

   // free-running 100 MHz clock
   initial
   begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   // one-cycle strobes are latched here so tasks may look later
   always @(posedge i_mclk)
   begin
      if (o_cmd_valid === 1'b1) n_cmd++;
      if (o_cmd_valid === 1'b1) cmd_id = o_cmd_id;
      if (o_pipe_rx_valid === 1'b1) n_raw++;
      if (o_pipe_rx_valid === 1'b1) raw_b = o_pipe_rx_data;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   // bounded wait for n bytes from the link
   task automatic wait_rx(input int n);
      for (int t = 0; t < 200 * BC && u_host_uart_model.rxq.size() < n; t++)
         @(negedge i_mclk);
   endtask : wait_rx

   // header type, length 0000 lsb first, id, then the plain byte sum
   task automatic send_cmd(input logic [7:0] cid, input logic [7:0] bad);
      u_host_uart_model.send(PKT_CMD);
      u_host_uart_model.send(8'h00);
      u_host_uart_model.send(8'h00);
      u_host_uart_model.send(cid);
      u_host_uart_model.send(PKT_CMD + cid + bad);
      repeat (4) @(negedge i_mclk);
   endtask : send_cmd

   // one-cycle request, event or response
   task automatic pulse(input logic is_evt, input logic [15:0] c);
      // only the chosen strobe moves, so back-to-back event and response calls never touch one signal twice
      if (is_evt)
      begin
         check(o_evt_ready, 16'h0001);
         i_evt_code = c;
         i_evt_valid = 1'b1;
      end
      else
      begin
         i_rsp_code = c;
         i_rsp_valid = 1'b1;
      end
      @(negedge i_mclk);
      if (is_evt)
         i_evt_valid = 1'b0;
      else
         i_rsp_valid = 1'b0;
   endtask : pulse

   // expected packet worked out from type, id and code, checked byte by byte
   task automatic get_pkt(input logic [7:0] typ, input logic [7:0] pid, input logic [15:0] c);
      logic [7:0] e[7];
      e = '{typ, 8'h02, 8'h00, pid, c[7:0], c[15:8], 8'h00};
      e[6] = typ + 8'h02 + pid + c[7:0] + c[15:8];
      wait_rx(7);
      for (int i = 0; i < 7; i++)
         check(u_host_uart_model.rxq.size() ? u_host_uart_model.rxq.pop_front() : 8'hXX,
               e[i]);
   endtask : get_pkt

   // hang guard, several times the expected run length
   initial
   begin
      #(8000 * BC * 10);
      n_mismatch++;
      complete_run();
   end

   initial
   begin
      void'($urandom(32'h974FA2D0));
      // defaults: flow control off; deep sleep never enabled, so no low-power handshake
      {i_rst_n, i_flow_en, i_pipe_up, stall, i_rsp_valid, i_evt_valid, i_pipe_tx_valid} = 7'h00;
      {i_pipe_sel_n, i_rsp_code, i_evt_code, i_pipe_tx_data} = 41'h10000000000;
      repeat (16) @(negedge i_mclk);
      i_rst_n = 1'b1;
      repeat (2) @(negedge i_mclk);
      check(o_data_ready_n, 16'h0001);
      check(o_conn_n, 16'h0001);
      check(o_rts_n, 16'h0000);
      // random commands; second raises an event mid-command, last runs flow-controlled
      for (int k = 0; k < 4; k++)
      begin
         id = 8'($urandom);
         code = 16'($urandom);
         ecode = 16'($urandom);
         i_flow_en = (k == 3);
         stall = (k == 3);
         send_cmd(id, 8'h00);
         check(16'(n_cmd), 16'(k + 1));
         check(cmd_id, id);
         if (k == 1) pulse(1'b1, ecode);
         pulse(1'b0, code);
         check(16'(u_host_uart_model.n_pend_fall), 16'(k + 1));
         if (k == 3) repeat (40 * BC) @(negedge i_mclk);
         check(16'(u_host_uart_model.rxq.size()), 16'h0000);
         check(o_data_ready_n, 16'h0000);
         stall = 1'b0;
         get_pkt(PKT_RSP, id, code);
         if (k == 1) get_pkt(PKT_EVT, 8'h00, ecode);
      end
      pulse(1'b1, ecode);
      get_pkt(PKT_EVT, 8'h00, ecode);
      // corrupt checksum and a stray response both draw no answer
      send_cmd(8'h5A, 8'h01);
      pulse(1'b0, 16'h1234);
      repeat (100 * BC) @(negedge i_mclk);
      check(16'(n_cmd), 16'h0004);
      check(16'(u_host_uart_model.rxq.size()), 16'h0000);
      check(16'(u_host_uart_model.n_frame_err), 16'h0000);
      // data pipe up: raw bytes both ways, sent only while connection shows low
      i_pipe_up = 1'b1;
      repeat (3) @(negedge i_mclk);
      check(o_conn_n, 16'h0000);
      u_host_uart_model.send(id);
      repeat (2) @(negedge i_mclk);
      check(16'(n_raw), 16'h0001);
      check(raw_b, id);
      check(o_pipe_tx_ready, 16'h0001);
      i_pipe_tx_data = ~id;
      i_pipe_tx_valid = 1'b1;
      @(negedge i_mclk);
      i_pipe_tx_valid = 1'b0;
      wait_rx(1);
      // the concatenation keeps the inversion to eight bits
      check(u_host_uart_model.rxq.size() ? u_host_uart_model.rxq.pop_front() : 8'hXX,
            {8'h00, ~id});
      // strap forces data mode: no events, commands ignored
      i_pipe_up = 1'b0;
      i_pipe_sel_n = 1'b0;
      repeat (3) @(negedge i_mclk);
      check(o_conn_n, 16'h0001);
      check(o_evt_ready, 16'h0000);
      send_cmd(id, 8'h00);
      check(16'(n_cmd), 16'h0004);
      complete_run();
   end
endmodule : test_serial_api_host_link
`default_nettype wire
